// *** dv/tb_timer_slave_mode_controller.sv ***
/*
 * self-checking bench of the slave-mode controller: avalon-mm register
 * access, every slave mode, trigger routing, sync delay and interrupt.
 * assumes tsmc_pkg compiled first and the far side model beside it.
 */
`timescale 1ns/100ps
module tb_timer_slave_mode_controller
   import tsmc_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic avs_response_err;
   logic [10:0] lines;
   logic count_step;
   logic count_down;
   logic counter_reinit;
   logic trigger_event;
   logic counter_enable_out;
   logic [31:0] dma_interrupt_enable_out;
   logic irq;
   logic [31:0] q;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   int n_step = 0;
   int n_down = 0;
   int n_reinit = 0;
   int t_trig = 0;
   int t_step = 0;
   int s = 0;
   int sd = 0;
   int d = 0;
   int src[8] = '{4, 1, 2, 3, 9, 5, 6, 10};
   int em[3] = '{1, 2, 3};
   int ed[3] = '{8, 7, 5};
   int lv[3] = '{7, 8, 6};

   always #5 clock = ~clock;

   tsmc_far_model far_u (.clock(clock), .lines(lines));

   tsmc_ctrl dut_u (
      .clock(clock), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response_err(avs_response_err),
      .trig_timer1(lines[0]), .trig_timer2(lines[1]), .trig_timer3(lines[2]),
      .trig_timer4(lines[3]), .trig_timer5(lines[4]),
      .filtered_input1_path1(lines[5]), .filtered_input2_path2(lines[6]),
      .filtered_input1_path2(lines[7]), .filtered_input2_path1(lines[8]),
      .input1_edge_detector(lines[9]), .filtered_external_trigger(lines[10]),
      .count_step(count_step), .count_down(count_down), .counter_reinit(counter_reinit),
      .trigger_event(trigger_event), .counter_enable_out(counter_enable_out),
      .dma_interrupt_enable_out(dma_interrupt_enable_out), .irq(irq)
   );

   // ************************************************************
   // counter-side monitor
   // ************************************************************
   // pre-edge values of registered pulses; the bench reads them at negedges
   always @(posedge clock) begin
      cyc++;
      if (count_step === 1'b1) begin
         n_step++;
         t_step = cyc;
         if (count_down === 1'b1) n_down++;
      end
      if (counter_reinit === 1'b1) n_reinit++;
      if (trigger_event === 1'b1) t_trig = cyc;
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // request held until the rising edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask : wt

   task automatic test_done();
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      test_done();
   end

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         bus(1'b0, 4'(a * 4), 32'h0, q);
         chk(q, 32'h0);
      end
      // unaligned offset is unmapped: reads zero, error flagged
      bus(1'b0, 4'h2, 32'h0, q);
      chk(q, 32'h0);
      chk(avs_response_err, 1'b1);
      bus(1'b1, 4'hc, 32'hffff_ffff, q);
      bus(1'b0, 4'hc, 32'h0, q);
      chk(q, 32'h0000_7fff);
      chk(dma_interrupt_enable_out, 32'h0000_7fff);
      bus(1'b1, 4'hc, 32'h0, q);
      avs_byteenable <= 4'h2;
      bus(1'b1, 4'hc, 32'hffff_ffff, q);
      avs_byteenable <= 4'hf;
      bus(1'b0, 4'hc, 32'h0, q);
      chk(q, 32'h0000_7f00);
      bus(1'b1, 4'hc, 32'h0, q);
      // internal clock needs the enable bit
      bus(1'b1, 4'h8, 32'h0001_0000, q);
      wt(1);
      chk(counter_enable_out, 1'b1);
      bus(1'b1, 4'h8, 32'h0, q);
      wt(1);
      chk(counter_enable_out, 1'b0);
      // every source, with a wrong source pulsed first
      for (int t = 0; t < 8; t++) begin
         bus(1'b1, 4'h8, 32'(4 + t * 16), q);
         wt(1);
         s = n_reinit;
         far_u.pulse(src[(t + 1) % 8]);
         far_u.pulse(0);
         wt(3);
         chk(n_reinit - s, 0);
         far_u.pulse(src[t]);
         wt(3);
         chk(n_reinit - s, 1);
      end
      // encoders: either direction rule gives four downs over both levels
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 4'h8, 32'h0001_0000 | 32'(em[i]), q);
         d = 0;
         for (int l = 0; l < 2; l++) begin
            far_u.set(lv[i], 1'(l));
            wt(3);
            s = n_step;
            sd = n_down;
            far_u.pulse(ed[i]);
            far_u.pulse(ed[i]);
            wt(3);
            chk(n_step - s, 4);
            d += n_down - sd;
         end
         chk(d, 4);
         far_u.set(lv[i], 1'b0);
      end
      // gated on filtered_external_trigger: runs while high, holds without reinit when low
      bus(1'b1, 4'h8, 32'h0001_0075, q);
      wt(3);
      s = n_step;
      sd = n_reinit;
      far_u.set(10, 1'b1);
      wt(5);
      far_u.set(10, 1'b0);
      wt(3);
      chk((n_step - s) >= 4 && (n_step - s) <= 8, 1'b1);
      s = n_step;
      wt(6);
      chk(n_step - s, 0);
      chk(n_reinit - sd, 0);
      // trigger mode starts the counter, no reinit
      bus(1'b1, 4'h8, 32'h76, q);
      far_u.pulse(10);
      wt(3);
      bus(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0001_0076);
      chk(counter_enable_out, 1'b1);
      chk(n_reinit - sd, 0);
      // external clock 1, an unselected input pulsed too
      bus(1'b1, 4'h8, 32'h0001_0077, q);
      wt(1);
      s = n_step;
      repeat (3) far_u.pulse(10);
      far_u.pulse(5);
      wt(3);
      chk(n_step - s, 3);
      bus(1'b1, 4'h8, 32'h0001_4000, q);
      wt(1);
      s = n_step;
      repeat (3) far_u.pulse(10);
      wt(3);
      chk(n_step - s, 3);
      // sync bit adds one cycle between trigger and step
      bus(1'b1, 4'h8, 32'h0001_0077, q);
      far_u.pulse(10);
      wt(3);
      chk(t_step - t_trig, 1);
      bus(1'b1, 4'h8, 32'h0001_00f7, q);
      far_u.pulse(10);
      wt(3);
      chk(t_step - t_trig, 2);
      // sticky trigger flag, mask, clear by writing one
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q & 32'h1, 32'h1);
      bus(1'b1, 4'h4, 32'h0, q);
      wt(1);
      chk(irq, 1'b0);
      bus(1'b1, 4'h4, 32'h7, q);
      wt(1);
      chk(irq, 1'b1);
      bus(1'b1, 4'h0, 32'h7, q);
      wt(1);
      chk(irq, 1'b0);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h0);
      far_u.pulse(10);
      wt(3);
      chk(irq, 1'b1);
      test_done();
   end
endmodule : tb_timer_slave_mode_controller

// *** dv/tsmc_far_model.sv ***
/*
 * far side of the slave-mode controller: master timer triggers and the
 * filtered, polarity-corrected timer inputs, driven as plain levels.
 * assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/100ps
module tsmc_far_model (
   // clock
   input wire logic clock,
   // line order: trig_timer1..5, fp1p1, fp2p2, fp1p2, fp2p1, edge detector, filtered_external_trigger
   output logic [10:0] lines
);
   // ************************************************************
   // line drivers
   // ************************************************************
   // all lines idle low, so the slave sees no event before its clock runs
   initial begin
      lines = 11'h000;
   end

   // levels only change right after a rising edge, never while the bench
   // rewrites the mode, so no event meets a mode change
   task automatic set(input int idx, input logic val);
      @(posedge clock);
      lines[idx] <= val;
   endtask : set

   // one high cycle; the edge detector line is only ever pulsed like this,
   // and the bench never pairs it with gated mode
   task automatic pulse(input int idx);
      set(idx, 1'b1);
      set(idx, 1'b0);
      @(posedge clock);
   endtask : pulse
endmodule : tsmc_far_model

// *** hw/tsmc_ctrl.sv ***
/*
 * slave-mode controller of an advanced timer: trigger selection, slave
 * modes, encoder stepping, counter enable and reset requests, Avalon-MM slave.
 * assumes filtered, polarity-corrected inputs synchronous to clock and a
 * counter outside that obeys count_step, count_down and counter_reinit.
 */
// Local design decision: the Avalon-MM slave port.
// What this block does
// - external trigger edge follows its input polarity
// - mode 000 with enable: count internal clock
// - mode 001: count input2 edges, input1 direction
// - mode 010: count input1 edges, input2 direction
// - mode 011: count both edges, other sets direction
// - reset mode: rising trigger reinits, updates registers
// - gated mode without ece: count only while trigger high
// - trigger mode: rising edge starts, no reset
// - external clock 1: each rising trigger counts
// - enable register at 0x0c, rw, resets zero
// - trigger select picks one of eight sources
// - external clock 2 acts as mode 1 on filtered_external_trigger
// - sync bit delays trigger effect one cycle
`timescale 1ns/100ps
module tsmc_ctrl
   import tsmc_pkg::*;
#(
   parameter bit INSTANCE_SECOND = 1'b0
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   // trigger outputs of the other timers
   input wire logic trig_timer1,
   input wire logic trig_timer2,
   input wire logic trig_timer3,
   input wire logic trig_timer4,
   input wire logic trig_timer5,
   // filtered, polarity-corrected inputs
   input wire logic filtered_input1_path1,
   input wire logic filtered_input2_path2,
   input wire logic filtered_input1_path2,
   input wire logic filtered_input2_path1,
   input wire logic input1_edge_detector,
   input wire logic filtered_external_trigger,
   // counter control
   output logic count_step,
   output logic count_down,
   output logic counter_reinit,
   output logic trigger_event,
   output logic counter_enable_out,
   output logic [31:0] dma_interrupt_enable_out,
   output logic irq
);

   // ************************************************************
   // registers and bus slave
   // ************************************************************
   logic [31:0] slave_mode_control_r;
   logic [31:0] dma_interrupt_enable_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic rd_pend_r;
   logic [31:0] rdata_r;
   logic err_r;
   logic [31:0] be_mask;
   logic wr_smcr, wr_dier, wr_stat, wr_mask, mapped;
   logic trig_start;
   logic [2:0] irq_evt;
   logic run_r;

   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   always_comb begin
      mapped = 1'b1;
      wr_smcr = 1'b0;
      wr_dier = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (avs_address == `TSMC_OFF_SMCR) begin
         wr_smcr = avs_write;
      end else if (avs_address == `TSMC_OFF_DIER) begin
         wr_dier = avs_write;
      end else if (avs_address == `TSMC_OFF_IRQ_STAT) begin
         wr_stat = avs_write;
      end else if (avs_address == `TSMC_OFF_IRQ_MASK) begin
         wr_mask = avs_write;
      end else begin
         mapped = 1'b0;
      end
   end

   // writes complete in the cycle they are seen; reads take one wait cycle
   assign avs_waitrequest = avs_read & ~rd_pend_r;
   assign avs_readdata = rdata_r;
   assign avs_response_err = err_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slave_mode_control_r <= `TSMC_SMCR_RESET;
      end else if (wr_smcr) begin
         slave_mode_control_r <= ((slave_mode_control_r & ~be_mask) | (avs_writedata & be_mask))
                                 & `TSMC_SMCR_MASK;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dma_interrupt_enable_r <= `TSMC_DIER_RESET;
      end else if (wr_dier) begin
         dma_interrupt_enable_r <= ((dma_interrupt_enable_r & ~be_mask) | (avs_writedata & be_mask))
                                   & `TSMC_DIER_MASK;
      end
   end
   assign dma_interrupt_enable_out = dma_interrupt_enable_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= `TSMC_IRQ_RESET;
      end else if (wr_mask && avs_byteenable[0]) begin
         irq_mask_r <= avs_writedata[2:0];
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= `TSMC_IRQ_RESET;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_stat && avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0))
                       | irq_evt;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         rd_pend_r <= avs_read & ~rd_pend_r;
         err_r <= (avs_read | avs_write) & ~mapped;
         if (avs_read && !rd_pend_r) begin
            if (avs_address == `TSMC_OFF_SMCR) begin
               // bit16 reads the live enable, so a trigger-mode start shows
               rdata_r <= {slave_mode_control_r[31:17], run_r, slave_mode_control_r[15:0]};
            end else if (avs_address == `TSMC_OFF_DIER) begin
               rdata_r <= dma_interrupt_enable_r;
            end else if (avs_address == `TSMC_OFF_IRQ_STAT) begin
               rdata_r <= {29'h0000_0000, irq_stat_r};
            end else if (avs_address == `TSMC_OFF_IRQ_MASK) begin
               rdata_r <= {29'h0000_0000, irq_mask_r};
            end else begin
               rdata_r <= 32'h0000_0000;
            end
         end
      end
   end

   // ************************************************************
   // trigger selection
   // ************************************************************
   tsmc_sms_t slave_mode_select;
   tsmc_ts_t ts;
   logic master_slave_sync, ece;
   logic internal_trigger_0, internal_trigger_1, internal_trigger_2, internal_trigger_3;
   logic trigger_input;

   assign slave_mode_select = tsmc_sms_t'(slave_mode_control_r[`TSMC_SMS_LSB +: 3]);
   assign ts = tsmc_ts_t'(slave_mode_control_r[`TSMC_TS_LSB +: 3]);
   assign master_slave_sync = slave_mode_control_r[`TSMC_MSM_BIT];
   assign ece = slave_mode_control_r[`TSMC_ECE_BIT];

   // the two instances see different masters on codes 0, 2 and 3
   assign internal_trigger_0 = INSTANCE_SECOND ? trig_timer1 : trig_timer5;
   assign internal_trigger_1 = trig_timer2;
   assign internal_trigger_2 = INSTANCE_SECOND ? trig_timer4 : trig_timer3;
   assign internal_trigger_3 = INSTANCE_SECOND ? trig_timer5 : trig_timer4;

   // external inputs arrive already corrected for their polarity
   always_comb begin
      case (ts)
         TSMC_TS_INTERNAL_TRIGGER_0: trigger_input = internal_trigger_0;
         TSMC_TS_INTERNAL_TRIGGER_1: trigger_input = internal_trigger_1;
         TSMC_TS_INTERNAL_TRIGGER_2: trigger_input = internal_trigger_2;
         TSMC_TS_INTERNAL_TRIGGER_3: trigger_input = internal_trigger_3;
         TSMC_TS_EDGE: trigger_input = input1_edge_detector;
         TSMC_TS_IN1: trigger_input = filtered_input1_path1;
         TSMC_TS_IN2: trigger_input = filtered_input2_path2;
         default: trigger_input = filtered_external_trigger;
      endcase
   end

   // ************************************************************
   // edge detection and master/slave delay
   // ************************************************************
   logic trg_prev_r, trg_d_r, etr_prev_r;
   logic in1a_prev_r, in2a_prev_r, in1b_prev_r, in2b_prev_r;
   logic trg_eff, trg_rise_raw, trg_rise, etr_rise;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trg_prev_r <= 1'b0;
         trg_d_r <= 1'b0;
         etr_prev_r <= 1'b0;
         in1a_prev_r <= 1'b0;
         in2a_prev_r <= 1'b0;
         in1b_prev_r <= 1'b0;
         in2b_prev_r <= 1'b0;
      end else begin
         trg_prev_r <= trigger_input;
         trg_d_r <= trg_eff;
         etr_prev_r <= filtered_external_trigger;
         in1a_prev_r <= filtered_input1_path1;
         in2a_prev_r <= filtered_input2_path2;
         in1b_prev_r <= filtered_input1_path2;
         in2b_prev_r <= filtered_input2_path1;
      end
   end

   // sync mode acts one cycle late so trigger_event reaches slaves first
   assign trg_eff = master_slave_sync ? trg_prev_r : trigger_input;
   assign trg_rise_raw = trigger_input & ~trg_prev_r;
   assign trg_rise = trg_eff & ~trg_d_r;
   assign etr_rise = filtered_external_trigger & ~etr_prev_r;
   assign trigger_event = trg_rise_raw;

   // ************************************************************
   // slave mode control
   // ************************************************************
   logic step_c, dir_c, reinit_c;
   logic e1a, e2a, e1b, e2b;

   assign e1a = filtered_input1_path1 ^ in1a_prev_r;
   assign e2a = filtered_input2_path2 ^ in2a_prev_r;
   assign e1b = filtered_input1_path2 ^ in1b_prev_r;
   assign e2b = filtered_input2_path1 ^ in2b_prev_r;
   assign trig_start = (slave_mode_select == TSMC_SMS_TRIG) && trg_rise && !run_r;

   // run flag is the counter enable, also set by trigger mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 1'b0;
      end else if (wr_smcr && avs_byteenable[2]) begin
         run_r <= avs_writedata[`TSMC_CEN_BIT] | trig_start;
      end else if (trig_start) begin
         run_r <= 1'b1;
      end
   end

   // quadrature: input2 rising edge counts up when input1 is low, input1 rising edge counts down when input2 is low
   always_comb begin
      step_c = 1'b0;
      dir_c = 1'b0;
      reinit_c = 1'b0;
      case (slave_mode_select)
         TSMC_SMS_OFF: step_c = run_r;
         TSMC_SMS_ENC1: begin
            step_c = run_r & e2b;
            dir_c = filtered_input2_path1 ~^ filtered_input1_path2;
         end
         TSMC_SMS_ENC2: begin
            step_c = run_r & e1b;
            dir_c = filtered_input1_path2 ^ filtered_input2_path1;
         end
         TSMC_SMS_ENC3: begin
            step_c = run_r & (e1a | e2a);
            dir_c = e1a ? (filtered_input1_path1 ^ filtered_input2_path2)
                        : (filtered_input2_path2 ~^ filtered_input1_path1);
         end
         TSMC_SMS_RESET: begin
            step_c = run_r;
            reinit_c = trg_rise;
         end
         TSMC_SMS_GATED: step_c = run_r & trg_eff;
         TSMC_SMS_TRIG: step_c = run_r;
         default: step_c = run_r & trg_rise;
      endcase
      // external clock 2 overrides the clock source and the gated-mode gate, not the reinit, start or direction
      if (ece) begin
         step_c = run_r & etr_rise;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_step <= 1'b0;
         count_down <= 1'b0;
         counter_reinit <= 1'b0;
      end else begin
         count_step <= step_c;
         count_down <= dir_c;
         counter_reinit <= reinit_c;
      end
   end
   assign counter_enable_out = run_r;
   assign irq_evt = {counter_reinit, trig_start, trg_rise};

   // ************************************************************
   // checks
   // ************************************************************
   property p_dier_reset;
      @(posedge clock) $rose(rst_n) |-> dma_interrupt_enable_r == 32'h0000_0000;
   endproperty
   a_dier_reset: assert property (p_dier_reset) else $error("enable reg not zero");

   property p_reinit;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_RESET && trg_rise && !wr_smcr) |=> counter_reinit;
   endproperty
   a_reinit: assert property (p_reinit) else $error("reset mode missed reinit");

   property p_gated;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_GATED && !trg_eff && !ece) |=> !count_step;
   endproperty
   a_gated: assert property (p_gated) else $error("gated mode counted while low");

   property p_trig_start;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_TRIG && trg_rise && !wr_smcr) |=> run_r ##1 count_step;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger mode no start");

   property p_ext1;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_EXT1 && !ece && run_r) |=> count_step == $past(trg_rise);
   endproperty
   a_ext1: assert property (p_ext1) else $error("ext clock 1 step mismatch");

   property p_off;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_OFF && !ece) |=> count_step == $past(run_r);
   endproperty
   a_off: assert property (p_off) else $error("internal clock step wrong");

   property p_msm;
      @(posedge clock) disable iff (!rst_n)
      (master_slave_sync && !wr_smcr) |-> trg_eff == $past(trigger_input);
   endproperty
   a_msm: assert property (p_msm) else $error("sync delay wrong");

   property p_ece;
      @(posedge clock) disable iff (!rst_n)
      (ece && !run_r) |=> !count_step;
   endproperty
   a_ece: assert property (p_ece) else $error("ext clock 2 counted stopped");

   property p_enc1;
      @(posedge clock) disable iff (!rst_n)
      (slave_mode_select == TSMC_SMS_ENC1 && !ece && run_r && !e2b) |=> !count_step;
   endproperty
   a_enc1: assert property (p_enc1) else $error("encoder 1 stray step");

   c_reinit: cover property (@(posedge clock) counter_reinit);
   c_trig: cover property (@(posedge clock) trig_start);
   c_enc_down: cover property (@(posedge clock) count_step && count_down);
   c_irq: cover property (@(posedge clock) irq);
endmodule : tsmc_ctrl

// *** pkg/tsmc_params.svh ***
/*
 * constants for the timer slave-mode controller: offsets, fields, resets.
 * assumes inclusion by bare name from the package.
 */
`ifndef TSMC_PARAMS_SVH
`define TSMC_PARAMS_SVH

// ************************************************************
// register offsets (byte addresses, word index = addr[3:2])
// ************************************************************
`define TSMC_OFF_SMCR 4'h8
`define TSMC_OFF_DIER 4'hc
`define TSMC_OFF_IRQ_STAT 4'h0
`define TSMC_OFF_IRQ_MASK 4'h4

// ************************************************************
// fields of the slave mode control register
// ************************************************************
`define TSMC_SMS_LSB 0
`define TSMC_TS_LSB 4
`define TSMC_MSM_BIT 7
`define TSMC_ECE_BIT 14
`define TSMC_CEN_BIT 16
`define TSMC_SMCR_MASK 32'h0001_40f7
`define TSMC_SMCR_RESET 32'h0000_0000
`define TSMC_DIER_MASK 32'h0000_7fff
`define TSMC_DIER_RESET 32'h0000_0000
`define TSMC_IRQ_BITS 3
`define TSMC_IRQ_RESET 3'h0

`endif

// *** pkg/tsmc_pkg.sv ***
/*
 * types for the timer slave-mode controller.
 * assumes tsmc_params.svh is on the include path.
 */
package tsmc_pkg;
   `include "tsmc_params.svh"

   typedef enum logic [2:0] {
      TSMC_SMS_OFF = 3'b000,
      TSMC_SMS_ENC1 = 3'b001,
      TSMC_SMS_ENC2 = 3'b010,
      TSMC_SMS_ENC3 = 3'b011,
      TSMC_SMS_RESET = 3'b100,
      TSMC_SMS_GATED = 3'b101,
      TSMC_SMS_TRIG = 3'b110,
      TSMC_SMS_EXT1 = 3'b111
   } tsmc_sms_t;

   typedef enum logic [2:0] {
      TSMC_TS_INTERNAL_TRIGGER_0 = 3'b000,
      TSMC_TS_INTERNAL_TRIGGER_1 = 3'b001,
      TSMC_TS_INTERNAL_TRIGGER_2 = 3'b010,
      TSMC_TS_INTERNAL_TRIGGER_3 = 3'b011,
      TSMC_TS_EDGE = 3'b100,
      TSMC_TS_IN1 = 3'b101,
      TSMC_TS_IN2 = 3'b110,
      TSMC_TS_FILTERED_EXTERNAL_TRIGGER = 3'b111
   } tsmc_ts_t;
endpackage : tsmc_pkg
